/* logic/mem_board_bus_interface.sv */
// memory board bus interface: processor bus slave and nvram module driver
// assumes: processor bus pins are asynchronous; iic slave lives elsewhere
module mem_board_bus_interface (
    input  wire logic                                 clk_i,
    input  wire logic                                 nrst_i,
    input  wire logic                                 board_reset_i,
    input  wire logic                                 supply_low_i,
    input  wire mem_board_pkg::proc_req_type          proc_req_i,
    input  wire logic [31:0]                          proc_data_i,
    output logic      [31:0]                          proc_data_o,
    output logic                                      proc_data_oe_o,
    output logic                                      size_ack0_n_o,
    output logic                                      size_ack1_n_o,
    output logic      [3:0]                           byte_lanes_o,
    output logic      [mem_board_pkg::ADDR_W-1:0]     buffered_addr_o,
    output mem_board_pkg::module_ctl_type             module_ctl_o,
    output logic                                      sram_protect_n_o,
    input  wire logic [mem_board_pkg::BYTE_W-1:0]     module_data_i,
    output logic      [mem_board_pkg::BYTE_W-1:0]     module_data_o,
    output logic                                      module_data_oe_o,
    input  wire logic                                 module_present_n_i,
    output logic                                      module_present_o,
    output logic [3:0]                                access_size_o
);
    localparam int RW = $bits(mem_board_pkg::proc_req_type);

    // ------------------------------------------------------------
    // input synchronisation and reset
    // ------------------------------------------------------------
    mem_board_pkg::proc_req_type req;
    logic [RW-1:0]               req_bits;
    logic [2:0]                  misc_sync;
    logic                        in_reset;
    logic [39:0]                 data_sync;

    // idle bus: strobe high, cpu space inactive, read
    sync2 #(
        .W       (RW),
        .RST_VAL ({1'b1, 1'b1, 2'h0, 1'b1, {mem_board_pkg::ADDR_W{1'b0}}})
    ) u_req_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (proc_req_i),
        .q_o    (req_bits)
    );

    sync2 #(
        .W       (3),
        .RST_VAL (3'h5)
    ) u_misc_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    ({board_reset_i, supply_low_i, module_present_n_i}),
        .q_o    (misc_sync)
    );

    sync2 #(
        .W       (40),
        .RST_VAL (40'h0)
    ) u_data_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    ({proc_data_i, module_data_i}),
        .q_o    (data_sync)
    );

    assign req      = mem_board_pkg::proc_req_type'(req_bits);
    assign in_reset = !nrst_i || misc_sync[2];

    // ------------------------------------------------------------
    // lane decode
    // ------------------------------------------------------------
    logic [3:0] lanes;
    logic [2:0] nbytes;
    logic [1:0] a_lo;

    always_comb begin
        a_lo = req.proc_addr[1:0];
        case (req.operand_size)
            mem_board_pkg::SIZE_8:  nbytes = 3'h1;
            mem_board_pkg::SIZE_16: nbytes = 3'h2;
            mem_board_pkg::SIZE_24: nbytes = 3'h3;
            default:                nbytes = 3'h4;
        endcase
        // lane 3 is bits 31:24; offset 0 starts at the top lane
        lanes = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (i >= 32'(a_lo) && i < 32'(a_lo) + 32'(nbytes)) begin
                lanes[3 - i] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // cycle state machine
    // ------------------------------------------------------------
    mem_board_pkg::cycle_state_type state;
    mem_board_pkg::cycle_state_type next_state;
    logic [7:0]                     wait_cnt;
    logic [7:0]                     next_wait_cnt;
    logic                           is_nv;
    logic                           next_is_nv;
    logic                           rnw;
    logic                           next_rnw;
    logic [3:0]                     lane_reg;
    logic [3:0]                     next_lane_reg;
    logic [31:0]                    rdata;
    logic [31:0]                    next_rdata;
    logic                           protect_n;
    logic                           next_protect_n;
    logic                           hit_nv;

    assign hit_nv = req.proc_addr[mem_board_pkg::ADDR_W-1:mem_board_pkg::NV_WIN_LSB]
                    == mem_board_pkg::NV_WINDOW;

    always_comb begin
        next_state     = state;
        next_wait_cnt  = wait_cnt;
        next_is_nv     = is_nv;
        next_rnw       = rnw;
        next_lane_reg  = lane_reg;
        next_rdata     = rdata;
        next_protect_n = !(misc_sync[2] || misc_sync[1]);
        case (state)
            mem_board_pkg::ST_IDLE: begin
                // cpu space cycles are ignored entirely
                if (!req.addr_strobe_n && req.cpu_space_n) begin
                    next_state    = mem_board_pkg::ST_ACCESS;
                    next_wait_cnt = 8'(mem_board_pkg::ACCESS_CYCLES);
                    next_is_nv    = hit_nv;
                    next_rnw      = req.read_not_write;
                    next_lane_reg = lanes;
                end
            end
            mem_board_pkg::ST_ACCESS: begin
                if (req.addr_strobe_n || !req.cpu_space_n) begin
                    next_state = mem_board_pkg::ST_IDLE;
                end else if (wait_cnt == 8'h1) begin
                    next_state = mem_board_pkg::ST_ACK;
                    next_rdata = {data_sync[7:0], 24'h0};
                end else begin
                    next_wait_cnt = wait_cnt - 8'h1;
                end
            end
            mem_board_pkg::ST_ACK: begin
                if (req.addr_strobe_n) begin
                    next_state = mem_board_pkg::ST_END;
                end
            end
            mem_board_pkg::ST_END: begin
                next_state = mem_board_pkg::ST_IDLE;
            end
            default: begin
                next_state = mem_board_pkg::ST_IDLE;
            end
        endcase
        if (in_reset) begin
            next_state     = mem_board_pkg::ST_IDLE;
            next_wait_cnt  = 8'h0;
            next_is_nv     = 1'b0;
            next_rnw       = 1'b1;
            next_lane_reg  = 4'h0;
            next_rdata     = 32'h0;
            next_protect_n = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        state     <= next_state;
        wait_cnt  <= next_wait_cnt;
        is_nv     <= next_is_nv;
        rnw       <= next_rnw;
        lane_reg  <= next_lane_reg;
        rdata     <= next_rdata;
        protect_n <= next_protect_n;
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic active;
    logic [31:0] wdata;
    logic [31:0] next_wdata;
    mem_board_pkg::module_ctl_type mod_ctl;
    mem_board_pkg::module_ctl_type next_mod_ctl;
    logic [mem_board_pkg::ADDR_W-1:0] baddr;
    logic [mem_board_pkg::ADDR_W-1:0] next_baddr;

    assign active = (state == mem_board_pkg::ST_ACCESS) || (state == mem_board_pkg::ST_ACK);

    always_comb begin
        next_baddr = in_reset ? '0 : req.proc_addr;
        next_wdata = in_reset ? 32'h0 : data_sync[39:8];
        next_mod_ctl.buffered_addr_strobe_n = in_reset || !active;
        next_mod_ctl.sram_select_n = in_reset || !(active && is_nv && protect_n);
        next_mod_ctl.read_not_write = in_reset ? 1'b1 : rnw;
        next_mod_ctl.addr = in_reset ? '0 : req.proc_addr[mem_board_pkg::MOD_ADDR_W-1:0];
    end

    always_ff @(posedge clk_i) begin
        baddr   <= next_baddr;
        wdata   <= next_wdata;
        mod_ctl <= next_mod_ctl;
    end

    assign buffered_addr_o  = baddr;
    assign module_ctl_o     = mod_ctl;
    assign sram_protect_n_o = protect_n;
    assign module_present_o = !misc_sync[0];
    assign byte_lanes_o     = lane_reg;
    assign access_size_o    = lanes;
    // ack: ack0 ends; ack1 low for a 32-bit port, high for module byte port
    assign size_ack0_n_o    = !(state == mem_board_pkg::ST_ACK);
    assign size_ack1_n_o    = !(state == mem_board_pkg::ST_ACK && !is_nv);
    assign proc_data_o      = rdata;
    assign proc_data_oe_o   = (state == mem_board_pkg::ST_ACK) && rnw;
    assign module_data_o    = wdata[31:24];
    assign module_data_oe_o = active && is_nv && !rnw && !mod_ctl.sram_select_n;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_reset_idle;
        @(posedge clk_i) misc_sync[2] |=> state == mem_board_pkg::ST_IDLE;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("reset not held");

    property p_protect;
        @(posedge clk_i) disable iff (!nrst_i) (misc_sync[1] || misc_sync[2]) |=> !protect_n;
    endproperty
    a_protect: assert property (p_protect) else $error("protect not asserted");

    property p_select_gated;
        @(posedge clk_i) disable iff (!nrst_i)
            !mod_ctl.sram_select_n |-> $past(is_nv) && $past(protect_n) && $past(active);
    endproperty
    a_select_gated: assert property (p_select_gated) else $error("select outside window");

    property p_select_strobe;
        @(posedge clk_i) disable iff (!nrst_i)
            !mod_ctl.sram_select_n |-> !mod_ctl.buffered_addr_strobe_n;
    endproperty
    a_select_strobe: assert property (p_select_strobe) else $error("select without strobe");

    property p_cpu_space;
        @(posedge clk_i) disable iff (!nrst_i)
            (state == mem_board_pkg::ST_IDLE && !req.cpu_space_n) |=> size_ack0_n_o;
    endproperty
    a_cpu_space: assert property (p_cpu_space) else $error("cpu space acknowledged");

    property p_start;
        @(posedge clk_i) disable iff (!nrst_i || in_reset)
            (state == mem_board_pkg::ST_IDLE && !req.addr_strobe_n && req.cpu_space_n)
            |=> state == mem_board_pkg::ST_ACCESS;
    endproperty
    a_start: assert property (p_start) else $error("cycle not started");

    property p_ack_time;
        @(posedge clk_i) disable iff (!nrst_i || in_reset)
            $rose(state == mem_board_pkg::ST_ACCESS) && !req.addr_strobe_n && req.cpu_space_n
            ##1 (!req.addr_strobe_n && req.cpu_space_n)[*4] |=> !size_ack0_n_o;
    endproperty
    a_ack_time: assert property (p_ack_time) else $error("ack late");

    property p_width;
        @(posedge clk_i) disable iff (!nrst_i)
            !size_ack0_n_o |-> size_ack1_n_o == is_nv;
    endproperty
    a_width: assert property (p_width) else $error("port width wrong");

    property p_lanes8;
        @(posedge clk_i) disable iff (!nrst_i)
            req.operand_size == mem_board_pkg::SIZE_8 |-> $onehot(lanes);
    endproperty
    a_lanes8: assert property (p_lanes8) else $error("byte lane decode");

    c_read:  cover property (@(posedge clk_i) !size_ack0_n_o && rnw);
    c_write: cover property (@(posedge clk_i) !size_ack0_n_o && !rnw);
    c_nv:    cover property (@(posedge clk_i) !mod_ctl.sram_select_n);
endmodule : mem_board_bus_interface

/* logic/mem_board_pkg.sv */
// constants, encodings and carrier types for the memory board bus interface
// assumes: one 125 MHz clock, synchronous active-low reset
package mem_board_pkg;

    localparam int ADDR_W         = 27;
    localparam int MOD_ADDR_W     = 22;
    localparam int BYTE_W         = 8;
    localparam int CLK_PERIOD_NS  = 8;
    // processor bus timing: access time before acknowledge
    localparam int ACCESS_TIME_NS = 40;
    localparam int ACCESS_CYCLES  = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // nvram window: upper address bits that select the module
    localparam logic [4:0] NV_WINDOW = 5'h1F;
    localparam int NV_WIN_LSB     = 22;

    // operand size encodings {size1, size0}
    localparam logic [1:0] SIZE_32 = 2'h0;
    localparam logic [1:0] SIZE_8  = 2'h1;
    localparam logic [1:0] SIZE_16 = 2'h2;
    localparam logic [1:0] SIZE_24 = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_ACCESS = 4'h2,
        ST_ACK    = 4'h4,
        ST_END    = 4'h8
    } cycle_state_type;

    typedef struct packed {
        logic              addr_strobe_n;
        logic              read_not_write;
        logic [1:0]        operand_size;
        logic              cpu_space_n;
        logic [ADDR_W-1:0] proc_addr;
    } proc_req_type;

    typedef struct packed {
        logic                  buffered_addr_strobe_n;
        logic                  sram_select_n;
        logic                  read_not_write;
        logic [MOD_ADDR_W-1:0] addr;
    } module_ctl_type;

endpackage : mem_board_pkg

/* logic/sync2.sv */
// two-flop synchroniser for a bundle of asynchronous levels
// assumes: inputs come from pins outside the clk_i domain
module sync2 #(
    parameter int         W        = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_q;

    always_comb begin
        next_stage1 = nrst_i ? d_i : RST_VAL;
        next_q      = nrst_i ? stage1 : RST_VAL;
    end

    always_ff @(posedge clk_i) begin
        stage1 <= next_stage1;
        q_o    <= next_q;
    end
endmodule : sync2

/* verification/nvram_model.sv */
// nvram module model: byte-wide static ram behind the board's module port
// assumes: select, strobe and direction arrive registered from the board
module nvram_model (
    input  wire logic                          clk_i,
    input  wire mem_board_pkg::module_ctl_type ctl_i,
    input  wire logic [7:0]                    data_i,
    input  wire logic                          data_oe_i,
    output logic      [7:0]                    data_o,
    output logic                               present_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [16];
    logic [7:0] last = 8'h00;
    logic       drive;

    assign present_n_o = 1'b0;
    assign drive = !ctl_i.sram_select_n && ctl_i.read_not_write;
    // released lane shows the inverse of its last value, never a stale copy
    assign data_o = drive ? mem[ctl_i.addr[3:0]] : ~last;

    always_ff @(posedge clk_i) begin
        if (drive)
            last <= data_o;
        if (!ctl_i.sram_select_n && !ctl_i.read_not_write && data_oe_i)
            mem[ctl_i.addr[3:0]] <= data_i;
    end
endmodule : nvram_model

/* verification/mem_board_bus_interface_bench.sv */
// testbench for the memory board bus interface, bench plays the host cpu
// assumes: nvram_model sits on the module side
module mem_board_bus_interface_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic                          clk_i = 1'b0;
    logic                          nrst_i = 1'b0;
    logic                          board_reset_i = 1'b0;
    logic                          supply_low_i = 1'b0;
    mem_board_pkg::proc_req_type   req;
    logic [31:0]                   wdata;
    logic [31:0]                   rdata;
    logic                          doe, ack0, ack1, prot, mdoe, mpres_n, mpres;
    logic [3:0]                    lanes, asize;
    logic [26:0]                   baddr;
    mem_board_pkg::module_ctl_type mctl;
    logic [7:0]                    mdo, mdi;
    logic [31:0]                   c_rd, c_ba;
    logic [21:0]                   c_ma;
    logic [3:0]                    c_ln, c_as;
    logic                          c_a1, c_sel, c_oe;
    logic [1:0]                    seen;
    int                            n, mismatches = 0, num_checks = 0;

    mem_board_bus_interface dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .board_reset_i(board_reset_i), .supply_low_i(supply_low_i),
        .proc_req_i(req), .proc_data_i(wdata), .proc_data_o(rdata),
        .proc_data_oe_o(doe), .size_ack0_n_o(ack0), .size_ack1_n_o(ack1),
        .byte_lanes_o(lanes), .buffered_addr_o(baddr), .module_ctl_o(mctl),
        .sram_protect_n_o(prot), .module_data_i(mdi), .module_data_o(mdo),
        .module_data_oe_o(mdoe), .module_present_n_i(mpres_n),
        .module_present_o(mpres), .access_size_o(asize));

    nvram_model partner (.clk_i(clk_i), .ctl_i(mctl), .data_i(mdo),
        .data_oe_i(mdoe), .data_o(mdi), .present_n_o(mpres_n));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // one whole cycle: strobe held until ack0 is seen low, then released
    task automatic bus(input logic [26:0] a, input logic rnw, input logic [1:0] sz,
                       input logic [31:0] wd);
        req = '{1'b0, rnw, sz, 1'b1, a};
        wdata = wd;
        n = 0;
        while (ack0 !== 1'b0 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        c_rd = rdata;
        c_a1 = ack1;
        c_sel = mctl.sram_select_n;
        c_ln = lanes;
        c_ma = mctl.addr;
        c_ba = 32'(baddr);
        c_oe = doe;
        c_as = asize;
        check(n < 40, 1'b1);
        req.addr_strobe_n = 1'b1;
        repeat (6) @(negedge clk_i);
    endtask : bus

    // track any answer while the strobe sits low for a fixed span
    task automatic hold_low(input logic [26:0] a, input logic cs_n);
        req = '{1'b0, 1'b1, mem_board_pkg::SIZE_8, cs_n, a};
        seen = 2'h0;
        repeat (12) begin
            @(negedge clk_i);
            if (ack0 !== 1'b1 || doe !== 1'b0)
                seen[1] = 1'b1;
            if (mctl.sram_select_n !== 1'b1)
                seen[0] = 1'b1;
        end
        req = '{1'b1, 1'b1, mem_board_pkg::SIZE_8, 1'b1, a};
        repeat (6) @(negedge clk_i);
    endtask : hold_low

    function automatic logic [3:0] exp_lanes(input int off, input logic [1:0] sz);
        int w;
        exp_lanes = 4'h0;
        w = (sz == mem_board_pkg::SIZE_32) ? 4 : int'(sz);
        for (int k = 0; k < 4; k++) begin
            if (k >= off && k < off + w)
                exp_lanes[3-k] = 1'b1;
        end
    endfunction : exp_lanes

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        check({ack0, prot, mctl.sram_select_n}, 3'h5);
        nrst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        check({prot, mpres}, 2'h3);
        $display("test reset done");
    endtask : t_reset

    task automatic t_module;
        bus(27'h7C00004, 1'b0, mem_board_pkg::SIZE_8, 32'hA5000000);
        check({c_sel, c_a1}, 2'h1);
        check(c_ma, 22'h000004);
        check(c_ba, 32'h07C00004);
        check(c_oe, 1'b0);
        bus(27'h7C00008, 1'b0, mem_board_pkg::SIZE_8, 32'h3C000000);
        bus(27'h7C00004, 1'b1, mem_board_pkg::SIZE_8, 32'h0);
        check(c_rd[31:24], 8'hA5);
        check(n >= 6 && n <= 8, 1'b1);
        check(c_oe, 1'b1);
        bus(27'h7C00008, 1'b1, mem_board_pkg::SIZE_8, 32'h0);
        check(c_rd[31:24], 8'h3C);
        $display("test module done");
    endtask : t_module

    task automatic t_lanes;
        for (int s = 0; s < 4; s++) begin
            for (int o = 0; o < 4; o++) begin
                bus(27'h0000100 | 27'(o), 1'b1, 2'(s), 32'h0);
                check(c_ln, exp_lanes(o, 2'(s)));
                check({c_a1, c_sel}, 2'h1);
                check(c_as, exp_lanes(o, 2'(s)));
            end
        end
        $display("test lanes done");
    endtask : t_lanes

    task automatic t_refuse;
        hold_low(27'h7C00004, 1'b0);
        check(seen, 2'h0);
        supply_low_i = 1'b1;
        repeat (4) @(negedge clk_i);
        check(prot, 1'b0);
        hold_low(27'h7C00004, 1'b1);
        check(seen, 2'h2);
        supply_low_i = 1'b0;
        repeat (4) @(negedge clk_i);
        check(prot, 1'b1);
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_mid_reset;
        req = '{1'b0, 1'b1, mem_board_pkg::SIZE_8, 1'b1, 27'h7C00004};
        repeat (4) @(negedge clk_i);
        board_reset_i = 1'b1;
        repeat (4) @(negedge clk_i);
        check({ack0, prot, mctl.sram_select_n, mctl.buffered_addr_strobe_n}, 4'hB);
        req.addr_strobe_n = 1'b1;
        board_reset_i = 1'b0;
        repeat (6) @(negedge clk_i);
        bus(27'h7C00004, 1'b1, mem_board_pkg::SIZE_8, 32'h0);
        check(c_rd[31:24], 8'hA5);
        $display("test mid reset done");
    endtask : t_mid_reset

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        req = '{1'b1, 1'b1, mem_board_pkg::SIZE_32, 1'b1, 27'h0};
        wdata = 32'h0;
        repeat (8) @(negedge clk_i);
        t_reset;
        t_module;
        t_lanes;
        t_refuse;
        t_mid_reset;
        test_done;
    end

    initial begin
        #100us;
        mismatches++;
        test_done;
    end
endmodule : mem_board_bus_interface_bench
